// ===== deser_lock_chk.sv
// checker: lock flag, tristate and word pulse timing
module deser_lock_chk
  import deser_lock_pkg::*;
#(
  parameter int LOSS_LIMIT = LOSS_COUNT,
  parameter int LOCK_LIMIT = LOCK_FRAMES
) (
  input logic ref_clk_i,
  input logic reset_i,
  input logic line_active_i,
  input logic power_save_n_i,
  input logic output_enable_i,
  input deser_lock_pkg::word_pins_t parallel_word_out_o,
  input logic word_suspect_o,
  input logic word_valid_o,
  input logic rclk_oe_o,
  input logic lock_n_o,
  input logic lock_n_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pwr_low_r;
  logic [5:0] line_low_r;
  // saturating counts of low cycles; the link-side crossing of these pins
  // takes up to about seventeen reference cycles, so a repetition is too short
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_low_r <= 6'h00;
      line_low_r <= 6'h00;
    end else begin
      pwr_low_r <= power_save_n_i ? 6'h00 : pwr_low_r + {5'h00, pwr_low_r != 6'h3F};
      line_low_r <= line_active_i ? 6'h00 : line_low_r + {5'h00, line_low_r != 6'h3F};
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // level inputs cross two sync flops first
  sequence off_s; !output_enable_i [*4]; endsequence
  data_float_a: assert property (lock_n_o [*2] |-> !parallel_word_out_o.oe)
    else $error("data driven");
  flag_float_a: assert property ($rose(lock_n_oe_o) |-> !lock_n_o)
    else $error("flag driven");
  rclk_float_a: assert property ($rose(rclk_oe_o) |-> !lock_n_o)
    else $error("clock driven");
  enable_off_a: assert property (off_s |-> !lock_n_oe_o && !rclk_oe_o)
    else $error("pins on");
  power_drop_a: assert property (pwr_low_r > 6'h18 |-> lock_n_o)
    else $error("lock held");
  line_drop_a: assert property (line_low_r > 6'h18 |-> lock_n_o)
    else $error("lock held");
  word_pulse_a: assert property (word_valid_o |=> !word_valid_o [*8])
    else $error("pulse gap");
  loss_suspect_a: assert property ($rose(lock_n_o) && power_save_n_i && line_active_i
    |-> ##[0:3] word_suspect_o) else $error("no suspect");
endmodule
bind serial_deserializer_lock deser_lock_chk #(.LOSS_LIMIT(LOSS_LIMIT), .LOCK_LIMIT(LOCK_LIMIT))
  i_deser_lock_chk (.ref_clk_i, .reset_i, .line_active_i, .power_save_n_i, .output_enable_i,
  .parallel_word_out_o, .word_suspect_o, .word_valid_o, .rclk_oe_o, .lock_n_o, .lock_n_oe_o);

// ===== deser_lock_pkg.sv
// shared constants and carrier types for the serial word receiver
package deser_lock_pkg;
  localparam int WORD_BITS = 10;
  localparam int FRAME_BITS = 12; // start clock bit, ten data bits, stop clock bit
  localparam int LOSS_COUNT = 4;
  localparam int SUSPECT_WORDS = 5;
  localparam int CLK_MHZ = 100;
  localparam logic [1:0] EMBED_PAIR = 2'h2; // start bit high, stop bit low
  localparam int LOCK_FRAMES = 8; // good framed words in a row to take lock
  localparam int SYNC_FRAMES = 2; // sync words in a row for fast lock
  // sent msb first: five ones, five zeros; only one frame alignment fits it
  localparam logic [9:0] SYNC_WORD = 10'h3E0;

  typedef struct packed {
    logic [WORD_BITS-1:0] data;
    logic suspect;
  } rx_word_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] o;
    logic [WORD_BITS-1:0] oe;
  } word_pins_t;
endpackage

// ===== ser_model.sv
// serializer model: framed words, sync on request
module ser_model
  import deser_lock_pkg::*;
(
  input logic link_clk_i,
  input logic reset_i,
  input logic req_a_i,
  input logic req_b_i,
  input logic bad_i,
  input logic line_active_i,
  input logic [9:0] word_i,
  output logic frame_o,
  output logic serial_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] sh_r;
  logic [3:0] cnt_r;
  // new frame every twelve bits; bad frames flip the clock bits
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= 4'h0;
      sh_r <= 12'h000;
    end else begin
      cnt_r <= (cnt_r == 4'hB) ? 4'h0 : cnt_r + 4'h1;
      sh_r <= (cnt_r != 4'h0) ? {sh_r[10:0], 1'b0} : {EMBED_PAIR[1] ^ bad_i,
        (req_a_i | req_b_i) ? SYNC_WORD : word_i, EMBED_PAIR[0] ^ bad_i};
    end
  end
  // released line shows noise flipping every bit
  assign frame_o = (cnt_r == 4'h1);
  assign serial_o = line_active_i ? sh_r[11] : cnt_r[0];
endmodule

// ===== serial_deserializer_lock.sv
// serial word receiver with lock detection and tristate pin control
// Contract
// RULE1 - twelve-bit frames: ten data, two clock bits
// RULE2 - lock flag high unless locked
// RULE3 - loss only after four bad frames
// RULE4 - last five words flagged suspect on loss
// RULE5 - sender resends five words after relock
// RULE6 - outputs float until data seen and locked
// RULE7 - reference clock runs before locking
// RULE8 - sender sends sync while request high
// RULE9 - lock flag feedback requests sync patterns
// RULE10 - random lock on plain data too
// RULE11 - words valid while lock flag low
// RULE12 - hold power-save low one microsecond
// RULE13 - alternate power-up: toggle power-save pin
// RULE14 - disconnected input: reject noise, float, unlock
// RULE15 - power-save low stops recovery loop
// RULE16 - output enable low floats all outputs; word_suspect_o and word_valid_o stay driven
// RULE17 - strobe select picks recovered clock edge
// RULE18 - one word per recovered clock period
module serial_deserializer_lock
  import deser_lock_pkg::*;
#(
  parameter int LOSS_LIMIT = LOSS_COUNT,
  parameter int LOCK_LIMIT = LOCK_FRAMES
) (
  input wire logic ref_clk_i, // local_reference_clk, 100 MHz
  input wire logic reset_i,
  input wire logic link_clk_i, // bit clock recovered at the link
  input wire logic serial_i,
  input wire logic line_active_i, // failsafe: carrier present on the line
  input wire logic power_save_n_i,
  input wire logic output_enable_i,
  input wire logic strobe_rising_i,
  output deser_lock_pkg::word_pins_t parallel_word_out_o,
  output logic word_suspect_o,
  output logic word_valid_o,
  output logic rclk_o,
  output logic rclk_oe_o,
  output logic lock_n_o,
  output logic lock_n_oe_o
);
  import deser_lock_pkg::*;

  typedef enum logic [1:0] {HUNT, LOCKED} lock_state_t;

  // ---------------- link domain ----------------
  logic [1:0] pwr_sync_r;
  logic [1:0] act_sync_r;
  logic [FRAME_BITS-1:0] shift_r;
  logic [3:0] bit_cnt_r;
  lock_state_t state_r;
  logic [3:0] good_cnt_r;
  logic [2:0] bad_cnt_r;
  logic [1:0] sync_cnt_r;
  logic [WORD_BITS-1:0] word_r;
  logic tog_r; // flips once per captured word
  logic locked_r;
  logic link_run;
  logic [FRAME_BITS-1:0] frame_now;
  logic frame_ok;
  logic is_sync;

  assign link_run = pwr_sync_r[1] & act_sync_r[1];
  assign frame_now = {shift_r[FRAME_BITS-2:0], serial_i};
  // frame: start clock bit, ten data bits, stop clock bit
  assign frame_ok = ({frame_now[FRAME_BITS-1], frame_now[0]} == EMBED_PAIR); // [RULE1]
  assign is_sync = frame_ok && (frame_now[WORD_BITS:1] == SYNC_WORD);

  // two-flop sync of power-save and carrier level into the link clock
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_sync_r <= 2'h0;
      act_sync_r <= 2'h0;
    end else begin
      pwr_sync_r <= {pwr_sync_r[0], power_save_n_i};
      act_sync_r <= {act_sync_r[0], line_active_i};
    end
  end

  // bit shifter; in hunt mode a bad frame slips one bit to search alignment
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_r <= '0;
      bit_cnt_r <= 4'h0;
    end else if (!link_run) begin // [RULE15]
      shift_r <= '0;
      bit_cnt_r <= 4'h0;
    end else begin
      shift_r <= frame_now;
      if (bit_cnt_r == 4'(FRAME_BITS - 1)) begin
        bit_cnt_r <= 4'h0;
      end else if (state_r == HUNT && bit_cnt_r == 4'h0 && !frame_ok) begin
        bit_cnt_r <= 4'h0; // stay at boundary, slide one bit
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // lock state machine, sync words or random data both acquire lock
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= HUNT;
      good_cnt_r <= 4'h0;
      bad_cnt_r <= 3'h0;
      sync_cnt_r <= 2'h0;
    end else if (!link_run) begin
      state_r <= HUNT; // [RULE14]
      good_cnt_r <= 4'h0;
      bad_cnt_r <= 3'h0;
      sync_cnt_r <= 2'h0;
    end else if (bit_cnt_r == 4'h0) begin
      case (state_r)
        HUNT: begin
          if (!frame_ok) begin
            good_cnt_r <= 4'h0;
            sync_cnt_r <= 2'h0;
          end else if (is_sync && sync_cnt_r == 2'(SYNC_FRAMES - 1)) begin
            state_r <= LOCKED;
            bad_cnt_r <= 3'h0;
          end else if (good_cnt_r == 4'(LOCK_LIMIT - 1)) begin
            state_r <= LOCKED; // [RULE10]
            bad_cnt_r <= 3'h0;
          end else begin
            good_cnt_r <= good_cnt_r + 4'h1;
            sync_cnt_r <= is_sync ? sync_cnt_r + 2'h1 : 2'h0;
          end
        end
        LOCKED: begin
          if (frame_ok) begin
            bad_cnt_r <= 3'h0;
          end else if (bad_cnt_r == 3'(LOSS_LIMIT - 1)) begin
            state_r <= HUNT; // [RULE3]
            good_cnt_r <= 4'h0;
            sync_cnt_r <= 2'h0;
          end else begin
            bad_cnt_r <= bad_cnt_r + 3'h1;
          end
        end
        default: state_r <= HUNT;
      endcase
    end
  end

  // capture one word per locked frame; the toggle announces it to the reference side
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      word_r <= '0;
      tog_r <= 1'b0;
      locked_r <= 1'b0;
    end else begin
      locked_r <= link_run && (state_r == LOCKED);
      if (link_run && bit_cnt_r == 4'h0 && state_r == LOCKED) begin
        word_r <= frame_now[WORD_BITS:1]; // [RULE18]
        tog_r <= ~tog_r;
      end
    end
  end

  // ---------------- reference domain ----------------
  logic [2:0] tog_sync_r;
  logic [2:0] lock_sync_r;
  logic [1:0] oe_sync_r;
  logic [1:0] edge_sync_r;
  rx_word_t out_r;
  logic valid_r;
  logic rclk_r;
  logic [SUSPECT_WORDS-1:0] susp_r;
  logic word_evt;
  logic locked_ref;
  logic lock_lost;

  assign word_evt = tog_sync_r[2] ^ tog_sync_r[1];
  assign locked_ref = lock_sync_r[1];
  // falling lock seen past the first flop, never on the metastable stage
  assign lock_lost = lock_sync_r[2] & ~lock_sync_r[1];

  // toggle and level crossings into the reference clock
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tog_sync_r <= 3'h0;
      lock_sync_r <= 3'h0;
      oe_sync_r <= 2'h0;
      edge_sync_r <= 2'h0;
    end else begin
      tog_sync_r <= {tog_sync_r[1:0], tog_r};
      lock_sync_r <= {lock_sync_r[1:0], locked_r};
      oe_sync_r <= {oe_sync_r[0], output_enable_i};
      edge_sync_r <= {edge_sync_r[0], strobe_rising_i};
    end
  end

  // word is stable across the rclk strobe edge chosen by the select pin;
  // data words are only re-read once per new word, so no tearing
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_r <= '0;
      valid_r <= 1'b0;
      rclk_r <= 1'b0;
      susp_r <= '0;
    end else begin
      valid_r <= word_evt && locked_ref; // [RULE11]
      if (word_evt) begin
        out_r.data <= word_r; // word_r held stable a full frame after toggle
        out_r.suspect <= 1'b0;
        susp_r <= {susp_r[SUSPECT_WORDS-2:0], 1'b0};
        rclk_r <= ~edge_sync_r[1]; // [RULE17]
      end else if (valid_r) begin
        rclk_r <= edge_sync_r[1];
      end
      // a loss in the cycle of a word shift wins over the shift
      if (lock_lost) begin
        susp_r <= '1; // [RULE4]
        out_r.suspect <= 1'b1;
      end
    end
  end

  // pins: float until locked, or whenever output enable is low
  always_comb begin
    parallel_word_out_o.o = out_r.data;
    parallel_word_out_o.oe = {WORD_BITS{oe_sync_r[1] & locked_ref}}; // [RULE6] [RULE16]
  end
  assign word_suspect_o = out_r.suspect | (|susp_r);
  assign word_valid_o = valid_r;
  assign rclk_o = rclk_r;
  assign rclk_oe_o = oe_sync_r[1] & locked_ref; // [RULE14]
  assign lock_n_o = ~locked_ref; // [RULE2]
  assign lock_n_oe_o = oe_sync_r[1] & locked_ref;
endmodule

// ===== testbench.sv
// bench: receiver against the serializer model
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import deser_lock_pkg::*;
  typedef struct packed {logic [9:0] w; logic sync; logic rise; logic [9:0] exp;} row_t;
  row_t rows[3] = '{'{10'h3FF, 1'b0, 1'b1, 10'h3FF}, '{10'h2AA, 1'b1, 1'b0, SYNC_WORD},
    '{10'h000, 1'b0, 1'b1, 10'h000}};
  logic ref_clk_i = 1'b0, link_clk_i = 1'b0, reset_i = 1'b1, line_active_i = 1'b1;
  logic power_save_n_i = 1'b0, output_enable_i = 1'b1, fb = 1'b1, req = 1'b0, bad = 1'b0;
  logic strobe = 1'b1;
  logic [9:0] word = 10'h000;
  logic serial_i, frm, word_suspect_o, word_valid_o, rclk_o, rclk_oe_o, lock_n_o, lock_n_oe_o;
  word_pins_t parallel_word_out_o;
  int num_errors = 0, checks = 0;
  // free running clocks, 10 ns and 48 ns
  always #5 ref_clk_i = ~ref_clk_i;
  // odd start phase keeps link edges off every reference edge
  initial begin
    #1.3;
    forever #24 link_clk_i = ~link_clk_i;
  end
  serial_deserializer_lock i_serial_deserializer_lock (.ref_clk_i, .reset_i, .link_clk_i,
    .serial_i, .line_active_i, .power_save_n_i, .output_enable_i, .strobe_rising_i(strobe),
    .parallel_word_out_o, .word_suspect_o, .word_valid_o, .rclk_o, .rclk_oe_o, .lock_n_o,
    .lock_n_oe_o);
  ser_model i_ser_model (.link_clk_i, .reset_i, .req_a_i(fb & lock_n_o), .req_b_i(req),
    .bad_i(bad), .line_active_i, .word_i(word), .frame_o(frm), .serial_o(serial_i));
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded waits: a dead link ends in a mismatch, not a hang
  task automatic wait_lock(input logic v);
    for (int n = 0; n < 5000 && lock_n_o !== v; n++) @(negedge ref_clk_i);
    check({9'h000, lock_n_o}, {9'h000, v});
  endtask
  task automatic wait_word(input logic [9:0] e);
    @(negedge ref_clk_i); // never reuse the pulse of the previous word
    for (int n = 0; n < 400 && (word_valid_o !== 1'b1 || parallel_word_out_o.o !== e); n++)
      @(negedge ref_clk_i);
    check(parallel_word_out_o.o, e);
  endtask
  task automatic stop_test;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // sync lock, word table, loss, random relock, pin controls
  initial begin
    repeat (10) @(negedge ref_clk_i);
    check(parallel_word_out_o.oe, 10'h000);
    reset_i = 1'b0;
    // power-save held low a full microsecond while supplies settle
    repeat (100) @(negedge ref_clk_i);
    check({9'h000, lock_n_o}, 10'h001);
    power_save_n_i = 1'b1;
    wait_lock(1'b0);
    foreach (rows[i]) begin
      word = rows[i].w;
      req = rows[i].sync;
      strobe = rows[i].rise;
      wait_word(rows[i].exp);
      check({9'h000, rclk_o}, {9'h000, ~rows[i].rise});
      @(negedge ref_clk_i);
      check({9'h000, rclk_o}, {9'h000, rows[i].rise});
    end
    req = 1'b0;
    bad = 1'b1;
    repeat (3) @(posedge frm);
    bad = 1'b0;
    repeat (4) @(posedge frm);
    @(negedge ref_clk_i);
    check({9'h000, lock_n_o}, 10'h000);
    fb = 1'b0;
    bad = 1'b1;
    repeat (4) @(posedge frm);
    bad = 1'b0;
    wait_lock(1'b1);
    repeat (3) @(negedge ref_clk_i);
    check({9'h000, word_suspect_o}, 10'h001);
    word = 10'h0C3;
    wait_lock(1'b0);
    wait_word(10'h0C3);
    // sender sends five new words while the suspect flag counts down
    for (int k = 0; k < SUSPECT_WORDS; k++) begin
      word = 10'h0C3 ^ 10'(k + 1);
      wait_word(10'h0C3 ^ 10'(k + 1));
    end
    check({9'h000, word_suspect_o}, 10'h000);
    output_enable_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    check(parallel_word_out_o.oe, 10'h000);
    check({8'h00, rclk_oe_o, lock_n_oe_o}, 10'h000);
    output_enable_i = 1'b1;
    repeat (5) @(negedge ref_clk_i);
    check(parallel_word_out_o.oe, 10'h3FF);
    power_save_n_i = 1'b0;
    wait_lock(1'b1);
    power_save_n_i = 1'b1;
    fb = 1'b1;
    wait_lock(1'b0);
    line_active_i = 1'b0;
    wait_lock(1'b1);
    check(parallel_word_out_o.oe, 10'h000);
    check({8'h00, rclk_oe_o, lock_n_oe_o}, 10'h000);
    stop_test;
  end
  // hang guard, about ten times the expected length of the run
  initial begin
    #300000;
    num_errors++;
    stop_test;
  end
endmodule
